// File: rtl/msp_pkg.sv
// shared constants of the motion state priority encoder
package msp_pkg;

  // register byte offsets
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_TARGET = 5'h08;
  localparam logic [4:0] REG_ACTPOS = 5'h0C;
  localparam logic [4:0] REG_SAFE = 5'h10;
  localparam logic [4:0] REG_PARAM = 5'h14;
  localparam logic [4:0] REG_DUAL = 5'h18;

  // command opcodes, cmd register bits 3:0
  localparam logic [3:0] OP_GOTO_SAFE = 4'h1;
  localparam logic [3:0] OP_TWO_STAGE = 4'h2;
  localparam logic [3:0] OP_RAMP_HALT = 4'h3;
  localparam logic [3:0] OP_IMM_HALT = 4'h4;

  // cmd register fields for the two-stage command
  localparam int CMD_VMAX_GIVEN_BIT = 4;
  localparam int CMD_VMAX_LSB = 8;
  localparam int CMD_FIRST_LSB = 16;

  // param register fields
  localparam int PAR_VMAX_LSB = 0;
  localparam int PAR_VMIN_LSB = 4;
  localparam int PAR_ACC_LSB = 8;
  localparam int PAR_PROFILE_BIT = 12;
  localparam logic [12:0] PARAM_RESET = 13'h0000;

  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_TSD_BIT = 3;
  localparam int ST_UV_BIT = 4;
  localparam int ST_ELDEF_BIT = 5;
  localparam int ST_CP_BIT = 6;
  localparam int ST_VDD_BIT = 7;
  localparam int ST_HS_BIT = 8;
  localparam int ST_MISSED_BIT = 9;
  localparam int ST_ERR_BIT = 10;
  localparam int ST_STOP_ORIGIN_BIT = 11;
  localparam int ST_SAFE_EN_BIT = 12;
  localparam int ST_PHASE2_BIT = 13;

  // safe target: most negative code disables it
  localparam logic [10:0] SAFE_DISABLED = 11'h400;
  localparam logic [15:0] POS_RESET = 16'h0000;
  localparam logic [15:0] DUAL_RESET = 16'h0000;

  // undervoltage hold time
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned UV_HOLD_S = 15;
  localparam int unsigned UV_HOLD_CYCLES = UV_HOLD_S * CLK_HZ;

  typedef enum logic [2:0] {
    MSP_IDLE,
    MSP_STOPPED,
    MSP_SEEK,
    MSP_TWO,
    MSP_RHALT,
    MSP_IHALT,
    MSP_UVHALT,
    MSP_SHUT
  } msp_state_e;

endpackage : msp_pkg

// File: rtl/msp_uv_timer.sv
// qualifies a level that must persist for a long hold time
`timescale 1ns/1ps
`default_nettype none
module msp_uv_timer #(
  parameter int unsigned HOLD = msp_pkg::UV_HOLD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // level in, qualified level out
  input wire logic level_i,
  output logic long_o
);

  localparam int W = $clog2(HOLD + 1);
  localparam logic [W-1:0] LAST = W'(HOLD);

  logic [W-1:0] cnt_q;

  // counts while low battery persists, restarts when it recovers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
      long_o <= 1'b0;
    end else if (!level_i) begin
      cnt_q <= '0;
      long_o <= 1'b0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + W'(1);
    end else begin
      long_o <= 1'b1;
    end
  end

endmodule : msp_uv_timer
`default_nettype wire

// File: rtl/msp_motion_fsm.sv
// motion state machine, fault flags and register slave
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - error flag is OR of four fault flags
// - power-on reset enters idle standby first
// - two-stage uses own params, rest from RAM
// - second motion forces profile select to one
// - readout reports RAM velocities, not sequence ones
// - shutdown held until thermal, hard and error flags clear
// - flags clear only after readout and fault gone
// - params written mid-sequence apply when the two-stage state is left
// - safe enable when safe target not most negative
// - stop-origin set on leaving either halt state
// - stop-origin cleared first edge in stopped
// - stopped to seeking at lowest priority
// - missed-step never blocks target or safe commands
// - missed-step cleared only by status readout
// - long undervoltage forces a halt state
// - coil defect sets hard flag, halts, missed-step
// - thermal: stopped to shutdown, moving to ramped
// - readout in shutdown may return to stopped
module msp_motion_fsm #(
  parameter int unsigned UV_HOLD = msp_pkg::UV_HOLD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // fault pins, asynchronous
  input wire logic thermal_i,
  input wire logic battery_low_i,
  input wire logic coil_defect_i,
  input wire logic charge_pump_fail_i,
  input wire logic logic_supply_reset_i,
  // motion generator, same clock
  input wire logic [15:0] act_pos_i,
  input wire logic motion_done_i,
  // motion outputs
  output logic [2:0] state_o,
  output logic [15:0] tag_pos_o,
  output logic [3:0] vmax_o,
  output logic [3:0] vmin_o,
  output logic [3:0] acc_o,
  output logic accel_profile_select_o,
  output logic safe_en_o,
  output logic stop_origin_o
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic moving(input msp_pkg::msp_state_e s);
    return s == msp_pkg::MSP_SEEK || s == msp_pkg::MSP_TWO;
  endfunction : moving

  // pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  assign pin_raw = {logic_supply_reset_i, charge_pump_fail_i, coil_defect_i,
                    battery_low_i, thermal_i};
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate
  logic thermal_s, batt_s, coil_s, cp_s, vdd_s, uv_long;
  assign {vdd_s, cp_s, coil_s, batt_s, thermal_s} = sync2_q;

  msp_uv_timer #(.HOLD(UV_HOLD)) u_uv_timer (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .level_i(batt_s),
    .long_o(uv_long)
  );

  // bus handshake: one wait cycle, then taken
  logic req, take;
  assign req = avs_read_i | avs_write_i;
  assign take = req & ~avs_waitrequest_o;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end
  end

  logic wr, readout, cmd_tgt, cmd_safe, cmd_two, cmd_rh, cmd_ih, par_wr;
  logic [3:0] op;
  assign wr = take & avs_write_i;
  assign op = avs_writedata_i[3:0];
  assign readout = take & avs_read_i & (avs_address_i == msp_pkg::REG_STATUS);
  assign cmd_tgt = wr & (avs_address_i == msp_pkg::REG_TARGET);
  assign par_wr = wr & (avs_address_i == msp_pkg::REG_PARAM);
  logic op_wr;
  assign op_wr = wr & (avs_address_i == msp_pkg::REG_CMD) & avs_byteenable_i[0];
  assign cmd_safe = op_wr & (op == msp_pkg::OP_GOTO_SAFE);
  assign cmd_two = op_wr & (op == msp_pkg::OP_TWO_STAGE);
  assign cmd_rh = op_wr & (op == msp_pkg::OP_RAMP_HALT);
  assign cmd_ih = op_wr & (op == msp_pkg::OP_IMM_HALT);

  // state and flags
  msp_pkg::msp_state_e state_q, st_d;
  logic tsd_q, uv_q, eldef_q, cp_q, vdd_q, hs_q, missed_q, phase2_q;
  logic [15:0] dual_q;
  logic [10:0] safe_q;
  logic [12:0] param_q;
  logic [3:0] seq_vmax_q, seq_vmin_q, seq_acc_q;
  logic seq_prof_q;
  logic err_agg;
  assign err_agg = cp_q | uv_q | eldef_q | vdd_q;

  logic halted, tag_ne;
  assign halted = state_q == msp_pkg::MSP_RHALT || state_q == msp_pkg::MSP_IHALT;
  assign tag_ne = act_pos_i != tag_pos_o;

  // next state, in priority order per state
  always_comb begin
    st_d = state_q;
    case (state_q)
      msp_pkg::MSP_IDLE: st_d = msp_pkg::MSP_STOPPED;
      msp_pkg::MSP_STOPPED: begin
        if (uv_long) st_d = msp_pkg::MSP_UVHALT;
        else if (tsd_q || hs_q) st_d = msp_pkg::MSP_SHUT;
        else if (stop_origin_o) st_d = msp_pkg::MSP_STOPPED;
        else if (cmd_two) st_d = msp_pkg::MSP_TWO;
        else if (cmd_tgt || (cmd_safe && safe_en_o)) st_d = msp_pkg::MSP_SEEK;
        else if (tag_ne) st_d = msp_pkg::MSP_SEEK;
      end
      msp_pkg::MSP_SEEK, msp_pkg::MSP_TWO: begin
        if (coil_s || cp_s || cmd_ih) st_d = msp_pkg::MSP_IHALT;
        else if (uv_long) begin
          st_d = (state_q == msp_pkg::MSP_TWO) ? msp_pkg::MSP_IHALT
                                               : msp_pkg::MSP_UVHALT;
        end else if (tsd_q || cmd_rh) st_d = msp_pkg::MSP_RHALT;
        else if (motion_done_i &&
                 (state_q == msp_pkg::MSP_SEEK || phase2_q))
          st_d = msp_pkg::MSP_STOPPED;
      end
      msp_pkg::MSP_RHALT: begin
        if (coil_s || cp_s || cmd_ih) st_d = msp_pkg::MSP_IHALT;
        else if (uv_long) st_d = msp_pkg::MSP_UVHALT;
        else if (motion_done_i) st_d = msp_pkg::MSP_STOPPED;
      end
      msp_pkg::MSP_IHALT: if (motion_done_i) st_d = msp_pkg::MSP_STOPPED;
      msp_pkg::MSP_UVHALT: if (motion_done_i) st_d = msp_pkg::MSP_SHUT;
      msp_pkg::MSP_SHUT: begin
        if (!tsd_q && !hs_q && !err_agg) st_d = msp_pkg::MSP_STOPPED;
      end
      default: st_d = msp_pkg::MSP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= msp_pkg::MSP_IDLE;
      state_o <= 3'(msp_pkg::MSP_IDLE);
    end else begin
      state_q <= st_d;
      state_o <= 3'(st_d);
    end
  end

  // sticky fault flags, set wins over clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tsd_q <= 1'b0;
      uv_q <= 1'b0;
      eldef_q <= 1'b0;
      cp_q <= 1'b0;
      vdd_q <= 1'b1;
      hs_q <= 1'b0;
    end else begin
      tsd_q <= thermal_s | (tsd_q & ~(readout & ~thermal_s));
      uv_q <= uv_long | (uv_q & ~(readout & ~batt_s));
      eldef_q <= coil_s | (eldef_q & ~(readout & ~coil_s));
      cp_q <= cp_s | (cp_q & ~(readout & ~cp_s));
      vdd_q <= vdd_s | (vdd_q & ~readout);
      hs_q <= coil_s | (hs_q & ~(readout & ~coil_s & ~thermal_s));
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      missed_q <= 1'b0;
    end else if ((coil_s || cp_s) && (moving(state_q) ||
                 state_q == msp_pkg::MSP_RHALT)) begin
      missed_q <= 1'b1;
    end else if (readout) begin
      missed_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_origin_o <= 1'b0;
    end else if (halted && st_d != state_q) begin
      stop_origin_o <= 1'b1;
    end else if (state_q == msp_pkg::MSP_STOPPED) begin
      stop_origin_o <= 1'b0;
    end
  end

  // target position, accepted regardless of missed-step
  logic tgt_ok;
  assign tgt_ok = state_q == msp_pkg::MSP_STOPPED || moving(state_q);
  // byte-lane merged write values
  logic [31:0] tgt_m, par_m, safe_m, dual_m;
  assign tgt_m = merge({16'h0000, tag_pos_o}, avs_writedata_i,
                       avs_byteenable_i);
  assign par_m = merge({19'h0_0000, param_q}, avs_writedata_i,
                       avs_byteenable_i);
  assign safe_m = merge({21'h00_0000, safe_q}, avs_writedata_i,
                        avs_byteenable_i);
  assign dual_m = merge({16'h0000, dual_q}, avs_writedata_i,
                        avs_byteenable_i);
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tag_pos_o <= msp_pkg::POS_RESET;
    end else if ((halted || state_q == msp_pkg::MSP_UVHALT) && motion_done_i) begin
      tag_pos_o <= act_pos_i;
    end else if (state_q == msp_pkg::MSP_STOPPED && cmd_two && st_d == cmd_two_st()) begin
      tag_pos_o <= avs_writedata_i[msp_pkg::CMD_FIRST_LSB +: 16];
    end else if (state_q == msp_pkg::MSP_TWO && !phase2_q && motion_done_i) begin
      tag_pos_o <= dual_q;
    end else if (tgt_ok && cmd_tgt) begin
      tag_pos_o <= tgt_m[15:0];
    end else if (tgt_ok && cmd_safe && safe_en_o) begin
      tag_pos_o <= {{5{safe_q[10]}}, safe_q};
    end
  end

  function automatic msp_pkg::msp_state_e cmd_two_st();
    return msp_pkg::MSP_TWO;
  endfunction : cmd_two_st

  // two-stage sequence phase and private parameter copy
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase2_q <= 1'b0;
      seq_vmax_q <= 4'h0;
      seq_vmin_q <= 4'h0;
      seq_acc_q <= 4'h0;
      seq_prof_q <= 1'b0;
    end else if (state_q != msp_pkg::MSP_TWO && st_d == msp_pkg::MSP_TWO) begin
      phase2_q <= 1'b0;
      seq_vmax_q <= avs_writedata_i[msp_pkg::CMD_VMAX_GIVEN_BIT]
                  ? avs_writedata_i[msp_pkg::CMD_VMAX_LSB +: 4]
                  : param_q[msp_pkg::PAR_VMAX_LSB +: 4];
      seq_vmin_q <= param_q[msp_pkg::PAR_VMIN_LSB +: 4];
      seq_acc_q <= param_q[msp_pkg::PAR_ACC_LSB +: 4];
      seq_prof_q <= param_q[msp_pkg::PAR_PROFILE_BIT];
    end else if (state_q == msp_pkg::MSP_TWO && motion_done_i) begin
      phase2_q <= 1'b1;
    end
  end

  // applied parameters, latched at each target command
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vmax_o <= 4'h0;
      vmin_o <= 4'h0;
      acc_o <= 4'h0;
      accel_profile_select_o <= 1'b0;
    end else if (st_d == msp_pkg::MSP_TWO) begin
      vmax_o <= seq_vmax_q;
      vmin_o <= seq_vmin_q;
      acc_o <= seq_acc_q;
      accel_profile_select_o <= phase2_q | seq_prof_q;
    end else if (cmd_tgt || cmd_safe || state_q == msp_pkg::MSP_TWO) begin
      vmax_o <= param_q[msp_pkg::PAR_VMAX_LSB +: 4];
      vmin_o <= param_q[msp_pkg::PAR_VMIN_LSB +: 4];
      acc_o <= param_q[msp_pkg::PAR_ACC_LSB +: 4];
      accel_profile_select_o <= param_q[msp_pkg::PAR_PROFILE_BIT];
    end
  end

  // software registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      param_q <= msp_pkg::PARAM_RESET;
      safe_q <= msp_pkg::SAFE_DISABLED;
      dual_q <= msp_pkg::DUAL_RESET;
    end else if (wr) begin
      if (par_wr) param_q <= par_m[12:0];
      if (avs_address_i == msp_pkg::REG_SAFE) safe_q <= safe_m[10:0];
      if (avs_address_i == msp_pkg::REG_DUAL) dual_q <= dual_m[15:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      safe_en_o <= 1'b0;
    end else begin
      safe_en_o <= safe_q != msp_pkg::SAFE_DISABLED;
    end
  end

  // read data, captured in the wait cycle
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[msp_pkg::ST_STATE_LSB +: 3] = 3'(state_q);
    status_w[msp_pkg::ST_TSD_BIT] = tsd_q;
    status_w[msp_pkg::ST_UV_BIT] = uv_q;
    status_w[msp_pkg::ST_ELDEF_BIT] = eldef_q;
    status_w[msp_pkg::ST_CP_BIT] = cp_q;
    status_w[msp_pkg::ST_VDD_BIT] = vdd_q;
    status_w[msp_pkg::ST_HS_BIT] = hs_q;
    status_w[msp_pkg::ST_MISSED_BIT] = missed_q;
    status_w[msp_pkg::ST_ERR_BIT] = err_agg;
    status_w[msp_pkg::ST_STOP_ORIGIN_BIT] = stop_origin_o;
    status_w[msp_pkg::ST_SAFE_EN_BIT] = safe_en_o;
    status_w[msp_pkg::ST_PHASE2_BIT] = phase2_q;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      case (avs_address_i)
        msp_pkg::REG_STATUS: avs_readdata_o <= status_w;
        msp_pkg::REG_TARGET: avs_readdata_o <= {16'h0000, tag_pos_o};
        msp_pkg::REG_ACTPOS: avs_readdata_o <= {16'h0000, act_pos_i};
        msp_pkg::REG_SAFE: avs_readdata_o <= {21'h00_0000, safe_q};
        msp_pkg::REG_PARAM: avs_readdata_o <= {19'h0_0000, param_q};
        msp_pkg::REG_DUAL: avs_readdata_o <= {16'h0000, dual_q};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : msp_motion_fsm
`default_nettype wire

// File: dv/msp_motion_sva.sv
// assertions on the motion state machine ports
`timescale 1ns/1ps
`default_nettype none
module msp_motion_sva #(
  parameter int unsigned UV_HOLD = 20
) (
  // clock, reset and bus
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // faults and motion outputs
  input wire logic thermal_i,
  input wire logic battery_low_i,
  input wire logic coil_defect_i,
  input wire logic [2:0] state_o,
  input wire logic safe_en_o,
  input wire logic stop_origin_o
);
  int unsigned uv_cnt_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uv_cnt_q <= 0;
    end else if (!battery_low_i) begin
      uv_cnt_q <= 0;
    end else if (uv_cnt_q < UV_HOLD + 9) begin
      uv_cnt_q <= uv_cnt_q + 1;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  reset_idle_first_a: assert property (
    !$past(arst_n_i) |-> state_o == 3'h0 ##1 state_o == 3'h1)
    else $error("no idle then stopped after reset");
  halt_exit_mark_a: assert property (
    ($past(state_o) == 3'h4 || $past(state_o) == 3'h5)
    && state_o != $past(state_o) |-> stop_origin_o)
    else $error("stop origin not set on halt exit");
  mark_clear_a: assert property (
    state_o == 3'h1 && $past(state_o) == 3'h1 |-> !stop_origin_o)
    else $error("stop origin not cleared in stopped");
  thermal_stop_a: assert property (
    thermal_i && state_o == 3'h1 |-> ##[1:6]
    (state_o == 3'h7 || state_o == 3'h4))
    else $error("thermal did not shut down");
  shut_hold_a: assert property (
    state_o == 3'h7 && thermal_i && $past(thermal_i) && $past(thermal_i, 2)
    |=> state_o == 3'h7)
    else $error("shutdown left while thermal high");
  coil_halt_a: assert property (
    coil_defect_i && state_o == 3'h2 |-> ##[1:6] state_o == 3'h5)
    else $error("coil defect did not halt");
  safe_enable_a: assert property (
    avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h10
    && avs_byteenable_i == 4'hf |-> ##2
    safe_en_o == ($past(avs_writedata_i[10:0], 2) != 11'h400))
    else $error("safe enable wrong");
  uv_long_halt_a: assert property (
    uv_cnt_q == UV_HOLD + 8 |-> state_o != 3'h1 && state_o != 3'h2
    && state_o != 3'h3)
    else $error("long undervoltage did not halt");
endmodule : msp_motion_sva
bind msp_motion_fsm msp_motion_sva #(.UV_HOLD(UV_HOLD)) u_sva (.*);
`default_nettype wire

// File: dv/msp_motion_gen.sv
// motion generator model: steps position, reports motion end
`timescale 1ns/1ps
`default_nettype none
module msp_motion_gen (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // state machine side
  input wire logic [2:0] state_i,
  input wire logic [15:0] tag_pos_i,
  output logic [15:0] act_pos_o,
  output logic motion_done_o
);
  logic [2:0] cnt_q;
  logic moving;
  assign moving = (state_i == 3'h2) || (state_i == 3'h3);
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_pos_o <= 16'h0000;
      motion_done_o <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      motion_done_o <= 1'b0;
      if (state_i >= 3'h4 && state_i <= 3'h6) begin
        motion_done_o <= (cnt_q == 3'h5);
      end else if (moving && act_pos_o == tag_pos_i) begin
        motion_done_o <= !motion_done_o;
      end else if (moving && cnt_q[0]) begin
        if ($signed(act_pos_o) < $signed(tag_pos_i)) begin
          act_pos_o <= act_pos_o + 16'h0001;
        end else begin
          act_pos_o <= act_pos_o - 16'h0001;
        end
      end
    end
  end
endmodule : msp_motion_gen
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench of the motion state machine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned UV_HOLD = 20;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic thermal_i = 1'b0;
  logic battery_low_i = 1'b0;
  logic coil_defect_i = 1'b0;
  logic charge_pump_fail_i = 1'b0;
  logic logic_supply_reset_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, motion_done_i, accel_profile_select_o;
  logic safe_en_o, stop_origin_o;
  logic [2:0] state_o;
  logic [15:0] act_pos_i, tag_pos_o;
  logic [3:0] vmax_o, vmin_o, acc_o;
  logic [31:0] st;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  msp_motion_fsm #(.UV_HOLD(UV_HOLD)) dut (.*);
  msp_motion_gen gen (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .state_i(state_o), .tag_pos_i(tag_pos_o), .act_pos_o(act_pos_i),
    .motion_done_o(motion_done_i));
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    st = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic rd_st();
    bus(1'b0, msp_pkg::REG_STATUS, 32'h0000_0000);
  endtask : rd_st
  task automatic wait_st(input logic [2:0] s);
    for (int n = 0; n < 2000 && state_o !== s; n++) begin
      @(posedge ref_clk_i);
    end
    chk(16'(state_o), 16'(s));
  endtask : wait_st
  task automatic t_reset();
    chk(16'(state_o), 16'h0001);
    rd_st();
    chk(st[15:0] & 16'h07f8, 16'h0480);
    rd_st();
    chk(st[15:0] & 16'h07f8, 16'h0000);
  endtask : t_reset
  task automatic t_safe();
    bus(1'b1, msp_pkg::REG_SAFE, 32'h0000_03ff);
    repeat (2) @(posedge ref_clk_i);
    chk(16'(safe_en_o), 16'h0001);
    bus(1'b1, msp_pkg::REG_SAFE, 32'h0000_0400);
    repeat (2) @(posedge ref_clk_i);
    chk(16'(safe_en_o), 16'h0000);
    bus(1'b1, msp_pkg::REG_SAFE, 32'h0000_0010);
    bus(1'b1, msp_pkg::REG_CMD, 32'(msp_pkg::OP_GOTO_SAFE));
    repeat (2) @(posedge ref_clk_i);
    chk(tag_pos_o, 16'h0010);
    wait_st(3'h1);
  endtask : t_safe
  task automatic t_halt();
    for (int op = 3; op <= 4; op++) begin
      bus(1'b1, msp_pkg::REG_TARGET, 32'h0000_0100);
      repeat (2) @(posedge ref_clk_i);
      chk(16'(state_o), 16'h0002);
      bus(1'b1, msp_pkg::REG_CMD, 32'(op));
      wait_st(3'h1);
      chk(16'(stop_origin_o), 16'h0001);
      @(posedge ref_clk_i);
      chk(16'(stop_origin_o), 16'h0000);
    end
  endtask : t_halt
  task automatic t_pump();
    bus(1'b1, msp_pkg::REG_TARGET, 32'h0000_0200);
    charge_pump_fail_i <= 1'b1;
    wait_st(3'h5);
    charge_pump_fail_i <= 1'b0;
    wait_st(3'h1);
    bus(1'b1, msp_pkg::REG_TARGET, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_i);
    chk(16'(state_o), 16'h0002);
    rd_st();
    chk(st[15:0] & 16'h0240, 16'h0240);
    wait_st(3'h1);
    rd_st();
    chk(st[15:0] & 16'h0200, 16'h0000);
  endtask : t_pump
  task automatic t_coil();
    bus(1'b1, msp_pkg::REG_TARGET, 32'h0000_0100);
    repeat (4) @(posedge ref_clk_i);
    coil_defect_i <= 1'b1;
    wait_st(3'h5);
    coil_defect_i <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rd_st();
    chk(st[15:0] & 16'h0320, 16'h0320);
    rd_st();
    wait_st(3'h1);
  endtask : t_coil
  task automatic t_heat();
    thermal_i <= 1'b1;
    wait_st(3'h7);
    rd_st();
    repeat (3) @(posedge ref_clk_i);
    chk(16'(state_o), 16'h0007);
    thermal_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rd_st();
    chk(st[15:0] & 16'h0008, 16'h0008);
    rd_st();
    wait_st(3'h1);
  endtask : t_heat
  task automatic t_uv();
    battery_low_i <= 1'b1;
    wait_st(3'h6);
    wait_st(3'h7);
    battery_low_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rd_st();
    rd_st();
    wait_st(3'h1);
  endtask : t_uv
  task automatic t_two();
    bus(1'b1, msp_pkg::REG_PARAM, 32'h0000_0123);
    bus(1'b1, msp_pkg::REG_DUAL, 32'h0000_0080);
    bus(1'b1, msp_pkg::REG_CMD, 32'h0040_0512);
    repeat (2) @(posedge ref_clk_i);
    chk(16'(state_o), 16'h0003);
    chk({4'h0, vmax_o, vmin_o, acc_o}, 16'h0521);
    bus(1'b1, msp_pkg::REG_PARAM, 32'h0000_0127);
    chk(16'(vmax_o), 16'h0005);
    bus(1'b0, msp_pkg::REG_PARAM, 32'h0000_0000);
    chk(st[15:0], 16'h0127);
    for (int n = 0; n < 2000 && tag_pos_o !== 16'h0080; n++) begin
      @(posedge ref_clk_i);
    end
    repeat (2) @(posedge ref_clk_i);
    chk(16'(accel_profile_select_o), 16'h0001);
    wait_st(3'h1);
    bus(1'b1, msp_pkg::REG_TARGET, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_i);
    chk({3'h0, accel_profile_select_o, vmax_o, vmin_o, acc_o},
      16'h0721);
  endtask : t_two
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_safe();
    t_halt();
    t_pump();
    t_coil();
    t_heat();
    t_uv();
    t_two();
    conclude();
  end
endmodule : testbench
`default_nettype wire
